/* gtu_top.sv */
// The Avalon-MM interface to the registers and the address map were left to the implementer.
`timescale 1ns/1ns
module gtu_top
  import gtu_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Avalon-MM slave
  input  wire logic [5:0]  address_i,
  input  wire logic        read_i,
  input  wire logic        write_i,
  input  wire logic [31:0] writedata_i,
  input  wire logic [3:0]  byteenable_i,
  output logic      [31:0] readdata_o,
  output logic             waitrequest_o,
  // Pins
  input  wire logic [NT-1:0] timer_input_pin_i,
  input  wire logic [NT-1:0] direction_input_pin_i,
  input  wire logic          capture_input_pin_i,
  output logic               core_toggle_output_o,
  output logic               second_core_toggle_output_o,
  output logic               second_core_overflow_o,
  // Interrupt
  output logic               irq_o
);

  // ****************************************
  // Declarations
  // ****************************************
  logic [CTRL_W-1:0] ctrl_r [NT];
  logic [CR_W-1:0]   crctrl_r;
  logic [TW-1:0]     creg_r;
  logic [ST_W-1:0]   stat_r;
  logic [ST_W-1:0]   mask_r;
  logic              core_latch_r;
  logic              score_latch_r;
  logic              sovf_r;
  logic              irq_r;
  logic              wait_r;
  logic [31:0]       rdata_r;
  logic [31:0]       rd_nxt;
  logic [PRE_W-1:0]  pre_r;

  logic [NT-1:0] in_lvl;
  logic [NT-1:0] in_rise;
  logic [NT-1:0] in_fall;
  logic [NT-1:0] dir_lvl;
  logic [NT-1:0] dir_rise;
  logic [NT-1:0] dir_fall;
  logic          cap_rise;
  logic          cap_fall;

  logic [TW-1:0] val    [NT];
  logic [TW-1:0] ld_val [NT];
  logic [NT-1:0] en;
  logic [NT-1:0] down;
  logic [NT-1:0] ld;
  logic [NT-1:0] wrap;
  logic [NT-1:0] sw_val_wr;
  logic [NT-1:0] sw_ctl_wr;

  logic core_lrise;
  logic core_lfall;
  logic sc_lrise;
  logic sc_lfall;
  logic cap_a;
  logic cap_b;
  logic rel_a;
  logic rel_b;
  logic cr_trig;
  logic wr_fire;
  logic [31:0]     wdata;
  logic [ST_W-1:0] ev;

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic edge_hit(input logic [1:0] sel,
                                    input logic       r,
                                    input logic       f);
    gtu_edge_t e;
    e = gtu_edge_t'(sel);
    case (e)
      E_RISE:  edge_hit = r;
      E_FALL:  edge_hit = f;
      E_BOTH:  edge_hit = r | f;
      default: edge_hit = 1'b0;
    endcase
  endfunction

  // Tick every 2**k cycles of the free-running prescaler
  function automatic logic pre_tick(input logic [PRE_W-1:0] c,
                                    input logic [2:0]       ps,
                                    input int               base);
    logic [PRE_W-1:0] m;
    m = PRE_W'((32'h1 << (base + int'(ps))) - 32'h1);
    pre_tick = (c & m) == m;
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0]  be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[8*b +: 8] = nw[8*b +: 8];
      end
    end
    merge = r;
  endfunction

  // ****************************************
  // Pin synchronisers
  // ****************************************
  genvar gi;
  generate
    for (gi = 0; gi < NT; gi++) begin : g_pins
      gtu_edge u_in (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .pin_i  (timer_input_pin_i[gi]),
        .lvl_o  (in_lvl[gi]),
        .rise_o (in_rise[gi]),
        .fall_o (in_fall[gi])
      );
      gtu_edge u_dir (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .pin_i  (direction_input_pin_i[gi]),
        .lvl_o  (dir_lvl[gi]),
        .rise_o (dir_rise[gi]),
        .fall_o (dir_fall[gi])
      );
    end
  endgenerate

  gtu_edge u_cap (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .pin_i  (capture_input_pin_i),
    .lvl_o  (),
    .rise_o (cap_rise),
    .fall_o (cap_fall)
  );

  // ****************************************
  // Prescaler
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pre_r <= '0;
    end else begin
      pre_r <= pre_r + 1'b1;
    end
  end

  // Latch transitions happen in the wrap cycle itself
  assign core_lrise = wrap[T_CORE] & ~core_latch_r;
  assign core_lfall = wrap[T_CORE] & core_latch_r;
  assign sc_lrise   = wrap[T_SCORE] & ~score_latch_r;
  assign sc_lfall   = wrap[T_SCORE] & score_latch_r;

  // ****************************************
  // Timers
  // ****************************************
  generate
    for (gi = 0; gi < NT; gi++) begin : g_tmr
      logic [CTRL_W-1:0] c;
      logic              tick;
      logic              srise;
      logic              sfall;
      logic              lclk;
      logic              qev;
      logic              qdown;
      logic              en_l;
      gtu_mode_t         md;
      gtu_role_t         rl;

      assign c    = ctrl_r[gi];
      assign md   = gtu_mode_t'(c[F_MODE +: 2]);
      assign rl   = (gi == T_AUXA || gi == T_AUXB) ?
                    gtu_role_t'(c[F_ROLE +: 2]) : R_COUNT;
      assign tick = pre_tick(pre_r, c[F_PS +: 3],
                             (gi >= T_SAUX) ? G2_BASE_LOG
                                            : G1_BASE_LOG);
      assign lclk = c[F_LCLK] && gi != T_CORE && gi != T_SCORE;
      // Concatenation: aux counts latch transitions of its group
      assign srise = lclk ? ((gi == T_SAUX) ? sc_lrise : core_lrise)
                          : in_rise[gi];
      assign sfall = lclk ? ((gi == T_SAUX) ? sc_lfall : core_lfall)
                          : in_fall[gi];
      assign qev   = in_rise[gi] | in_fall[gi] | dir_rise[gi]
                   | dir_fall[gi];
      assign qdown = (in_rise[gi] | in_fall[gi]) ?
                     (in_lvl[gi] == dir_lvl[gi]) :
                     (dir_lvl[gi] != in_lvl[gi]);

      always_comb begin
        en_l = 1'b0;
        if (c[F_RUN] && rl == R_COUNT) begin
          case (md)
            M_TIMER: en_l = tick;
            M_GATED: en_l = tick & (in_lvl[gi] == c[F_GHI]);
            M_COUNT: en_l = lclk ? (srise | sfall)
                     : edge_hit(c[F_EDGE +: 2], srise, sfall);
            M_INCR:  en_l = qev;
            default: en_l = 1'b0;
          endcase
        end
      end

      assign en[gi] = en_l;

      assign down[gi] = (md == M_INCR) ? (qdown ^ c[F_DOWN])
                      : (c[F_DOWN] ^ (c[F_EXTD] & dir_lvl[gi]));

      gtu_timer #(
        .W (TW)
      ) u_tmr (
        .clk_i      (clk_i),
        .rst_i      (rst_i),
        .cnt_en_i   (en[gi]),
        .down_i     (down[gi]),
        .load_i     (ld[gi]),
        .load_val_i (ld_val[gi]),
        .value_o    (val[gi]),
        .wrap_o     (wrap[gi])
      );
    end
  endgenerate

  // ****************************************
  // Capture and reload
  // ****************************************
  assign cap_a = ctrl_r[T_AUXA][F_ROLE +: 2] == R_CAPT &&
                 edge_hit(ctrl_r[T_AUXA][F_EDGE +: 2],
                          in_rise[T_AUXA], in_fall[T_AUXA]);
  assign cap_b = ctrl_r[T_AUXB][F_ROLE +: 2] == R_CAPT &&
                 edge_hit(ctrl_r[T_AUXB][F_EDGE +: 2],
                          in_rise[T_AUXB], in_fall[T_AUXB]);

  // Latch trigger lets A and B pick opposite transitions for PWM
  assign rel_a = ctrl_r[T_AUXA][F_ROLE +: 2] == R_RELOAD &&
                 (ctrl_r[T_AUXA][F_LTRG] ?
                  edge_hit(ctrl_r[T_AUXA][F_EDGE +: 2], core_lrise,
                           core_lfall) :
                  edge_hit(ctrl_r[T_AUXA][F_EDGE +: 2], in_rise[T_AUXA],
                           in_fall[T_AUXA]));
  assign rel_b = ctrl_r[T_AUXB][F_ROLE +: 2] == R_RELOAD &&
                 (ctrl_r[T_AUXB][F_LTRG] ?
                  edge_hit(ctrl_r[T_AUXB][F_EDGE +: 2], core_lrise,
                           core_lfall) :
                  edge_hit(ctrl_r[T_AUXB][F_EDGE +: 2], in_rise[T_AUXB],
                           in_fall[T_AUXB]));

  always_comb begin
    case (crctrl_r[F_CSRC +: 2])
      2'h0: cr_trig = edge_hit(crctrl_r[F_CEDGE +: 2], cap_rise,
                               cap_fall);
      2'h1: cr_trig = edge_hit(crctrl_r[F_CEDGE +: 2], in_rise[T_CORE],
                               in_fall[T_CORE]);
      2'h2: cr_trig = edge_hit(crctrl_r[F_CEDGE +: 2], dir_rise[T_CORE],
                               dir_fall[T_CORE]);
      default: cr_trig = edge_hit(crctrl_r[F_CEDGE +: 2],
                                  in_rise[T_CORE] | dir_rise[T_CORE],
                                  in_fall[T_CORE] | dir_fall[T_CORE]);
    endcase
  end

  // Software writes take priority over hardware loads of the timer values
  always_comb begin
    for (int i = 0; i < NT; i++) begin
      ld[i]     = sw_val_wr[i];
      ld_val[i] = TW'(merge({16'h0000, val[i]}, writedata_i,
                            byteenable_i));
    end
    if (!sw_val_wr[T_AUXA] && cap_a) begin
      ld[T_AUXA]     = 1'b1;
      ld_val[T_AUXA] = val[T_CORE];
    end
    if (!sw_val_wr[T_AUXB] && cap_b) begin
      ld[T_AUXB]     = 1'b1;
      ld_val[T_AUXB] = val[T_CORE];
    end
    if (!sw_val_wr[T_CORE] && (rel_a || rel_b)) begin
      ld[T_CORE]     = 1'b1;
      ld_val[T_CORE] = rel_a ? val[T_AUXA] : val[T_AUXB];
    end
    if (!sw_val_wr[T_SAUX] && cr_trig && crctrl_r[F_CCLR]) begin
      ld[T_SAUX]     = 1'b1;
      ld_val[T_SAUX] = '0;
    end
    if (!sw_val_wr[T_SCORE] && wrap[T_SCORE] && ctrl_r[T_SCORE][F_LTRG])
    begin
      ld[T_SCORE]     = 1'b1;
      ld_val[T_SCORE] = creg_r;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      creg_r <= '0;
    end else if (cr_trig) begin
      creg_r <= val[T_SAUX];
    end else if (wr_fire && address_i == OFS_CREG) begin
      creg_r <= wdata[TW-1:0];
    end
  end

  // ****************************************
  // Toggle latches and overflow output
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      core_latch_r  <= 1'b0;
      score_latch_r <= 1'b0;
      sovf_r        <= 1'b0;
    end else begin
      core_latch_r  <= core_latch_r ^ wrap[T_CORE];
      score_latch_r <= score_latch_r ^ wrap[T_SCORE];
      sovf_r        <= wrap[T_SCORE];
    end
  end

  assign core_toggle_output_o        = core_latch_r;
  assign second_core_toggle_output_o = score_latch_r;
  assign second_core_overflow_o      = sovf_r;

  // ****************************************
  // Interrupt flags
  // ****************************************
  assign ev = {cr_trig, cap_b, cap_a, wrap};

  // A new event wins over a clear in the same cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stat_r <= '0;
    end else if (wr_fire && address_i == OFS_STAT) begin
      stat_r <= (stat_r & ~wdata[ST_W-1:0]) | ev;
    end else begin
      stat_r <= stat_r | ev;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= |(stat_r & mask_r);
    end
  end

  assign irq_o = irq_r;

  // ****************************************
  // Avalon-MM slave
  // ****************************************
  // One wait cycle per access keeps read data registered
  assign wr_fire = write_i & ~wait_r;
  assign wdata   = merge(32'h0000_0000, writedata_i, byteenable_i);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wait_r <= 1'b1;
    end else if ((read_i || write_i) && wait_r) begin
      wait_r <= 1'b0;
    end else begin
      wait_r <= 1'b1;
    end
  end

  always_comb begin
    for (int i = 0; i < NT; i++) begin
      sw_ctl_wr[i] = wr_fire && address_i == OFS_CTRL0 + 6'(4 * i);
      sw_val_wr[i] = wr_fire && address_i == OFS_VAL0 + 6'(4 * i);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < NT; i++) begin
        ctrl_r[i] <= CTRL_RST;
      end
    end else begin
      for (int i = 0; i < NT; i++) begin
        if (sw_ctl_wr[i]) begin
          ctrl_r[i] <= CTRL_W'(merge({17'h0, ctrl_r[i]}, writedata_i,
                                     byteenable_i));
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      crctrl_r <= CR_RST;
      mask_r   <= '0;
    end else if (wr_fire && address_i == OFS_CRCTRL) begin
      crctrl_r <= CR_W'(merge({27'h0, crctrl_r}, writedata_i,
                              byteenable_i));
    end else if (wr_fire && address_i == OFS_MASK) begin
      mask_r   <= ST_W'(merge({24'h0, mask_r}, writedata_i,
                              byteenable_i));
    end
  end

  always_comb begin
    rd_nxt = 32'h0000_0000;
    for (int i = 0; i < NT; i++) begin
      if (address_i == OFS_CTRL0 + 6'(4 * i)) begin
        rd_nxt = {17'h0, ctrl_r[i]};
      end
      if (address_i == OFS_VAL0 + 6'(4 * i)) begin
        rd_nxt = {16'h0, val[i]};
      end
    end
    case (address_i)
      OFS_CRCTRL: rd_nxt = {27'h0, crctrl_r};
      OFS_CREG:   rd_nxt = {16'h0, creg_r};
      OFS_STAT:   rd_nxt = {22'h0, score_latch_r, core_latch_r, stat_r};
      OFS_MASK:   rd_nxt = {24'h0, mask_r};
      default:    ;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_r <= 32'h0000_0000;
    end else if (read_i && wait_r) begin
      rdata_r <= rd_nxt;
    end
  end

  assign readdata_o    = rdata_r;
  assign waitrequest_o = wait_r;

endmodule

/* gtu_pkg.sv */
package gtu_pkg;

  // ****************************************
  // Sizes
  // ****************************************
  localparam int TW     = 16;
  localparam int NT     = 5;
  localparam int CTRL_W = 15;
  localparam int CR_W   = 5;
  localparam int ST_W   = 8;
  localparam int PRE_W  = 12;

  // Timer indices: first group 0..2, second group 3..4
  localparam int T_AUXA  = 0;
  localparam int T_CORE  = 1;
  localparam int T_AUXB  = 2;
  localparam int T_SAUX  = 3;
  localparam int T_SCORE = 4;

  // Prescaler base, as log2 of system cycles per finest count
  localparam int G1_BASE_LOG = 2;
  localparam int G2_BASE_LOG = 1;

  // ****************************************
  // Register byte offsets
  // ****************************************
  localparam logic [5:0] OFS_CTRL0  = 6'h00;
  localparam logic [5:0] OFS_CRCTRL = 6'h14;
  localparam logic [5:0] OFS_VAL0   = 6'h20;
  localparam logic [5:0] OFS_CREG   = 6'h34;
  localparam logic [5:0] OFS_STAT   = 6'h38;
  localparam logic [5:0] OFS_MASK   = 6'h3C;

  // ****************************************
  // Timer control fields
  // ****************************************
  localparam int F_PS    = 0;
  localparam int F_MODE  = 3;
  localparam int F_RUN   = 5;
  localparam int F_DOWN  = 6;
  localparam int F_EXTD  = 7;
  localparam int F_GHI   = 8;
  localparam int F_EDGE  = 9;
  localparam int F_ROLE  = 11;
  localparam int F_LCLK  = 13;
  localparam int F_LTRG  = 14;

  // Capture/reload control fields
  localparam int F_CSRC  = 0;
  localparam int F_CCLR  = 2;
  localparam int F_CEDGE = 3;

  // Status bits 0..4 are timer wraps
  localparam int S_CAPA  = 5;
  localparam int S_CAPB  = 6;
  localparam int S_CREG  = 7;
  localparam int S_LATCH = 8;

  localparam logic [CTRL_W-1:0] CTRL_RST = 15'h0000;
  localparam logic [CR_W-1:0]   CR_RST   = 5'h00;

  typedef enum logic [1:0] {M_TIMER, M_GATED, M_COUNT, M_INCR} gtu_mode_t;
  typedef enum logic [1:0] {R_COUNT, R_CAPT, R_RELOAD, R_RSVD} gtu_role_t;
  typedef enum logic [1:0] {E_RISE, E_FALL, E_BOTH, E_NONE} gtu_edge_t;

endpackage

/* gtu_edge.sv */
`timescale 1ns/1ns
module gtu_edge (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // Asynchronous pin
  input  wire logic pin_i,
  // Synchronised level and edges
  output logic      lvl_o,
  output logic      rise_o,
  output logic      fall_o
);

  logic s1_r;
  logic s2_r;
  logic s3_r;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
    end else begin
      s1_r <= pin_i;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  assign lvl_o  = s2_r;
  assign rise_o = s2_r & ~s3_r;
  assign fall_o = ~s2_r & s3_r;

endmodule

/* gtu_timer.sv */
`timescale 1ns/1ns
module gtu_timer #(
  parameter int W = 16
) (
  // Clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  // Count control
  input  wire logic         cnt_en_i,
  input  wire logic         down_i,
  input  wire logic         load_i,
  input  wire logic [W-1:0] load_val_i,
  // State
  output logic      [W-1:0] value_o,
  output logic              wrap_o
);

  logic [W-1:0] cnt_r;

  // Load beats counting so a reload replaces the wrap value
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_r <= '0;
    end else if (load_i) begin
      cnt_r <= load_val_i;
    end else if (cnt_en_i) begin
      cnt_r <= down_i ? cnt_r - 1'b1 : cnt_r + 1'b1;
    end
  end

  assign value_o = cnt_r;
  assign wrap_o  = cnt_en_i & (down_i ? (cnt_r == '0) : (&cnt_r));

endmodule

/* gtu_top_chk.sv */
`timescale 1ns/1ns
module gtu_chk (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Bus
  input  wire logic        read_i,
  input  wire logic        write_i,
  input  wire logic [31:0] readdata_o,
  input  wire logic        waitrequest_o,
  // Events
  input  wire logic        second_core_toggle_output_o,
  input  wire logic        second_core_overflow_o,
  input  wire logic        irq_o
);
  logic lat_r;
  logic lat2_r;

  // Two samples back: latch and pulse land on the same edge; the check also accepts them one apart
  always_ff @(posedge clk_i) begin
    lat_r  <= second_core_toggle_output_o;
    lat2_r <= lat_r;
  end

  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // ********
  // Checks
  // ********
  property p_ans;
    waitrequest_o && (read_i || write_i) |=> !waitrequest_o;
  endproperty
  a_ans: assert property (p_ans)
    else $error("request not answered in one cycle");

  property p_one;
    !waitrequest_o |=> waitrequest_o;
  endproperty
  a_one: assert property (p_one)
    else $error("answer longer than one cycle");

  property p_idle;
    waitrequest_o && !read_i && !write_i |=> waitrequest_o;
  endproperty
  a_idle: assert property (p_idle)
    else $error("answer without request");

  property p_rdat;
    $changed(readdata_o) |-> $fell(waitrequest_o) && $past(read_i);
  endproperty
  a_rdat: assert property (p_rdat)
    else $error("read data moved outside a read");

  property p_hi0;
    readdata_o[31:16] == 16'h0000;
  endproperty
  a_hi0: assert property (p_hi0)
    else $error("read data wider than 16 bits");

  property p_ovf;
    second_core_overflow_o |=> !second_core_overflow_o;
  endproperty
  a_ovf: assert property (p_ovf)
    else $error("overflow pulse longer than one cycle");

  property p_lat;
    second_core_overflow_o |->
      (second_core_toggle_output_o != lat_r) || (lat_r != lat2_r);
  endproperty
  a_lat: assert property (p_lat)
    else $error("second latch did not flip on wrap");

  property p_irqf;
    $fell(irq_o) |-> $past(write_i) || $past(write_i, 2);
  endproperty
  a_irqf: assert property (p_irqf)
    else $error("irq dropped without a write");
endmodule

/* gtu_pins.sv */
`timescale 1ns/1ns
module gtu_pins
  import gtu_pkg::*;
(
  // Clock
  input  wire logic          clk_i,
  // Pin levels seen by the unit
  output logic      [NT-1:0] tin_o,
  output logic      [NT-1:0] dir_o,
  output logic               cap_o
);
  logic [1:0] ph_r = 2'h0;

  initial begin
    tin_o = '0;
    dir_o = '0;
    cap_o = 1'h0;
  end

  // Five cycles per level clears the two-flop synchroniser with margin
  task automatic drive(input int k, input int i, input logic v);
    @(posedge clk_i);
    if (k == 0)
      tin_o[i] <= v;
    else if (k == 1)
      dir_o[i] <= v;
    else
      cap_o <= v;
    repeat (4) @(posedge clk_i);
  endtask

  task automatic pulse(input int k, input int i);
    drive(k, i, 1'h1);
    drive(k, i, 1'h0);
  endtask

  // Gray order: only one sensor line changes per step
  task automatic quad(input int i, input int n, input bit back);
    logic a;
    for (int s = 0; s < n; s++) begin
      ph_r = back ? ph_r - 2'h1 : ph_r + 2'h1;
      a = ph_r[1] ^ ph_r[0];
      if (a != tin_o[i])
        drive(0, i, a);
      else
        drive(1, i, ph_r[1]);
    end
  endtask
endmodule

/* gtu_top_tb_top.sv */
`timescale 1ns/1ns
module gtu_top_tb_top
  import gtu_pkg::*;
;
  logic          clk_i = 1'h0;
  logic          rst_i = 1'h1;
  logic [5:0]    address_i = 6'h00;
  logic          read_i = 1'h0;
  logic          write_i = 1'h0;
  logic [31:0]   writedata_i = 32'h0;
  logic [31:0]   readdata_o;
  logic          waitrequest_o;
  logic [NT-1:0] tin;
  logic [NT-1:0] dir;
  logic          cap;
  logic          lat1;
  logic          lat2;
  logic          ovf;
  logic          irq_o;
  int            error_cnt = 0;
  int            compares = 0;

  always #4 clk_i = ~clk_i;

  gtu_top DUT (
    .clk_i(clk_i), .rst_i(rst_i), .address_i(address_i),
    .read_i(read_i), .write_i(write_i), .writedata_i(writedata_i),
    .byteenable_i(4'hF), .readdata_o(readdata_o),
    .waitrequest_o(waitrequest_o), .timer_input_pin_i(tin),
    .direction_input_pin_i(dir), .capture_input_pin_i(cap),
    .core_toggle_output_o(lat1), .second_core_toggle_output_o(lat2),
    .second_core_overflow_o(ovf), .irq_o(irq_o)
  );

  gtu_pins PIN (.clk_i(clk_i), .tin_o(tin), .dir_o(dir), .cap_o(cap));

  task automatic chk(input string nm, input logic [31:0] s, e);
    compares++;
    if (s !== e) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic acc(input logic w, input logic [5:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    address_i   <= a;
    writedata_i <= d;
    read_i      <= ~w;
    write_i     <= w;
    do begin
      @(posedge clk_i);
      n++;
    end while (waitrequest_o !== 1'h0 && n < 50);
    if (n == 50)
      chk("bus answer", 1'h0, 1'h1);
    q = readdata_o;
    read_i  <= 1'h0;
    write_i <= 1'h0;
  endtask

  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    logic [31:0] q;
    acc(1'h1, a, d, q);
  endtask

  task automatic rd(input logic [5:0] a, output logic [31:0] q);
    acc(1'h0, a, 32'h0, q);
  endtask

  function automatic logic [5:0] ctl(input int i);
    return OFS_CTRL0 + 6'(4 * i);
  endfunction

  function automatic logic [5:0] val(input int i);
    return OFS_VAL0 + 6'(4 * i);
  endfunction

  function automatic logic [31:0] cw(input int m, input int ex);
    return (32'(m) << F_MODE) | (32'h1 << F_RUN) | 32'(ex);
  endfunction

  task automatic await(ref logic s, input string nm);
    int n;
    n = 0;
    while (s !== 1'h1 && n < 300) begin
      @(posedge clk_i);
      n++;
    end
    chk(nm, s, 1'h1);
  endtask

  task automatic irq_is(input logic e);
    repeat (2) @(posedge clk_i);
    chk("irq", irq_o, e);
  endtask

  task automatic t_regs();
    logic [31:0] q;
    rd(ctl(T_CORE), q);
    chk("ctrl reset", q, 32'h0);
    wr(val(T_CORE), 32'hFFFFABCD);
    rd(val(T_CORE), q);
    chk("value 16 bit", q, 32'hABCD);
    wr(6'h18, 32'hFFFFFFFF);
    rd(6'h18, q);
    chk("unmapped", q, 32'h0);
    $display("regs done");
  endtask

  task automatic t_rate();
    logic [31:0] q;
    wr(val(T_CORE), 32'h0);
    wr(val(T_SCORE), 32'h0);
    wr(ctl(T_AUXB), cw(M_GATED, 1 << F_GHI));
    wr(ctl(T_AUXA), cw(M_GATED, 0));
    wr(ctl(T_CORE), cw(M_TIMER, 0));
    wr(ctl(T_SCORE), cw(M_TIMER, 0));
    repeat (40) @(posedge clk_i);
    wr(ctl(T_CORE), 32'h0);
    wr(ctl(T_SCORE), 32'h0);
    wr(ctl(T_AUXA), 32'h0);
    rd(val(T_CORE), q);
    chk("core 4 cycles", q >= 10 && q <= 13, 1'h1);
    rd(val(T_SCORE), q);
    chk("second 2 cycles", q >= 22 && q <= 24, 1'h1);
    rd(val(T_AUXA), q);
    chk("gate open", q >= 13 && q <= 14, 1'h1);
    rd(val(T_AUXB), q);
    chk("gate shut", q, 32'h0);
    $display("rate done");
  endtask

  task automatic t_cnt();
    logic [31:0] q;
    wr(val(T_AUXA), 32'h0);
    wr(ctl(T_AUXA), cw(M_COUNT, 1 << F_EXTD));
    repeat (5) PIN.pulse(0, T_AUXA);
    rd(val(T_AUXA), q);
    chk("count up", q, 32'h5);
    PIN.drive(1, T_AUXA, 1'h1);
    repeat (2) PIN.pulse(0, T_AUXA);
    rd(val(T_AUXA), q);
    chk("dir pin", q, 32'h3);
    wr(ctl(T_AUXA), cw(M_COUNT, 1 << F_DOWN));
    PIN.pulse(0, T_AUXA);
    rd(val(T_AUXA), q);
    chk("soft down", q, 32'h2);
    $display("count done");
  endtask

  task automatic t_quad();
    logic [31:0] a;
    logic [31:0] b;
    wr(val(T_AUXB), 32'h0);
    wr(ctl(T_AUXB), cw(M_INCR, 0));
    PIN.quad(T_AUXB, 8, 1'h0);
    rd(val(T_AUXB), a);
    PIN.quad(T_AUXB, 4, 1'h1);
    rd(val(T_AUXB), b);
    chk("quad", (a == 32'h8 && b == 32'h4) ||
                (a == 32'hFFF8 && b == 32'hFFFC), 1'h1);
    $display("quad done");
  endtask

  task automatic t_wrap();
    logic [31:0] q;
    wr(OFS_STAT, 32'hFF);
    wr(val(T_AUXA), 32'h0);
    wr(ctl(T_AUXA), cw(M_COUNT, 1 << F_LCLK));
    wr(OFS_MASK, 32'h2);
    wr(val(T_CORE), 32'hFFF0);
    wr(ctl(T_CORE), cw(M_TIMER, 0));
    await(irq_o, "irq on wrap");
    chk("core latch", lat1, 1'h1);
    wr(ctl(T_CORE), 32'h0);
    rd(val(T_AUXA), q);
    chk("chained", q, 32'h1);
    rd(OFS_STAT, q);
    chk("status", q[7:0], 8'h02);
    wr(OFS_MASK, 32'h0);
    irq_is(1'h0);
    wr(OFS_MASK, 32'h2);
    irq_is(1'h1);
    wr(OFS_STAT, 32'h2);
    irq_is(1'h0);
    $display("wrap done");
  endtask

  task automatic t_cap();
    logic [31:0] q;
    wr(val(T_CORE), 32'h55);
    wr(ctl(T_AUXA), cw(M_COUNT, R_CAPT << F_ROLE));
    PIN.pulse(0, T_AUXA);
    rd(val(T_AUXA), q);
    chk("capture", q, 32'h55);
    wr(val(T_AUXB), 32'h777);
    wr(ctl(T_AUXB), R_RELOAD << F_ROLE);
    PIN.pulse(0, T_AUXB);
    rd(val(T_CORE), q);
    chk("reload", q, 32'h777);
    $display("capture done");
  endtask

  task automatic hold(input logic v, output int n);
    n = 0;
    while (lat1 === v && n < 300) begin
      @(posedge clk_i);
      n++;
    end
  endtask

  // Aux A reloads on latch rise, aux B on latch fall
  task automatic t_pwm();
    int n;
    wr(val(T_AUXA), 32'hFFF0);
    wr(val(T_AUXB), 32'hFFF8);
    wr(ctl(T_AUXA), (R_RELOAD << F_ROLE) | (1 << F_LTRG));
    wr(ctl(T_AUXB), (R_RELOAD << F_ROLE) | (1 << F_LTRG)
                    | (E_FALL << F_EDGE));
    wr(val(T_CORE), 32'hFFFE);
    wr(ctl(T_CORE), cw(M_TIMER, 0));
    hold(1'h1, n);
    hold(1'h0, n);
    chk("pwm low", n, 32'h20);
    hold(1'h1, n);
    chk("pwm high", n, 32'h40);
    wr(ctl(T_CORE), 32'h0);
    $display("pwm done");
  endtask

  task automatic t_creg();
    logic [31:0] q;
    wr(val(T_SAUX), 32'h42);
    wr(OFS_CRCTRL, 1 << F_CCLR);
    PIN.pulse(2, 0);
    rd(OFS_CREG, q);
    chk("creg", q, 32'h42);
    rd(val(T_SAUX), q);
    chk("aux cleared", q, 32'h0);
    wr(val(T_SAUX), 32'h99);
    wr(OFS_CRCTRL, 32'h1);
    PIN.pulse(0, T_CORE);
    rd(OFS_CREG, q);
    chk("creg core pin", q, 32'h99);
    wr(val(T_SCORE), 32'hFFF8);
    wr(ctl(T_SCORE), cw(M_TIMER, 1 << F_LTRG));
    await(ovf, "overflow");
    chk("second latch", lat2, 1'h1);
    wr(ctl(T_SCORE), 32'h0);
    rd(val(T_SCORE), q);
    chk("wrap reload", q >= 32'h99 && q <= 32'h9F, 1'h1);
    $display("creg done");
  endtask

  task automatic results();
    $display("compares %0d errors %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'h0;
    t_regs();
    t_rate();
    t_cnt();
    t_quad();
    t_wrap();
    t_cap();
    t_pwm();
    t_creg();
    results();
  end

  // Whole run is about six hundred cycles; this is a generous ceiling
  initial begin
    #100000;
    chk("watchdog", 1'h0, 1'h1);
    results();
  end
endmodule

bind gtu_top gtu_chk CHK (
  .clk_i(clk_i), .rst_i(rst_i), .read_i(read_i), .write_i(write_i),
  .readdata_o(readdata_o), .waitrequest_o(waitrequest_o),
  .second_core_toggle_output_o(second_core_toggle_output_o),
  .second_core_overflow_o(second_core_overflow_o), .irq_o(irq_o)
);
